// >>> logic/swf_defines.vh
`ifndef SWF_DEFINES_VH
`define SWF_DEFINES_VH

// ****************************************
// system clock
// ****************************************
`define SWF_SYS_CLK_KHZ 40000
`define SWF_SYS_CLK_MHZ 40

// ****************************************
// printed times
// ****************************************
`define SWF_T_IN_DGL_US 200
`define SWF_T_RST_DGL_US 10
`define SWF_T_CLK_DGL_NS 2000
`define SWF_T_WD_SHORT_MS 32
`define SWF_T_WD_LONG_MS 128
`define SWF_F_CLK_LOW_HZ 100

// ****************************************
// derived cycle counts
// ****************************************
`define SWF_IN_DGL_CYC (`SWF_T_IN_DGL_US * `SWF_SYS_CLK_MHZ)
`define SWF_RST_DGL_CYC (`SWF_T_RST_DGL_US * `SWF_SYS_CLK_MHZ)
`define SWF_CLK_DGL_CYC ((`SWF_T_CLK_DGL_NS * `SWF_SYS_CLK_MHZ) / 1000)
`define SWF_WD_SHORT_CYC (`SWF_T_WD_SHORT_MS * `SWF_SYS_CLK_KHZ)
`define SWF_WD_LONG_CYC (`SWF_T_WD_LONG_MS * `SWF_SYS_CLK_KHZ)
`define SWF_CLK_LOW_CYC ((`SWF_SYS_CLK_KHZ * 1000) / `SWF_F_CLK_LOW_HZ)

// ****************************************
// widths and field positions
// ****************************************
`define SWF_DGL_CNT_W 14
`define SWF_LONG_CNT_W 23
`define SWF_FRAME_W 16
`define SWF_EDGE_CNT_W 8
`define SWF_FRAME_MOD_MSB 3
`define SWF_WD_BIT_POS 15
`define SWF_NUM_CH 4

// ****************************************
// mode states
// ****************************************
`define SWF_ST_SLEEP 2'h0
`define SWF_ST_NORMAL 2'h1
`define SWF_ST_FAIL 2'h2

`endif

// >>> logic/swf_deglitch.v
`timescale 1ns/1ps
`default_nettype none
`include "swf_defines.vh"

module swf_deglitch #(
  parameter [`SWF_DGL_CNT_W-1:0] DGL_CYC = 14'h0050,
  parameter FALL_ONLY = 0
) (
  // clock and control
  input wire sys_clk,
  input wire srst,
  input wire clk_en,
  // pin and filtered level
  input wire pin_in,
  output reg filt_out
);

  reg sync_a;
  reg sync_b;
  reg [`SWF_DGL_CNT_W-1:0] cnt;

  // ****************************************
  // two-stage sync, then a stability counter
  // ****************************************
  always @(posedge sys_clk) begin
    if (srst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= {`SWF_DGL_CNT_W{1'b0}};
      filt_out <= 1'b0;
    end else if (clk_en) begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      if (sync_b == filt_out) begin
        cnt <= {`SWF_DGL_CNT_W{1'b0}};
      end else if (FALL_ONLY != 0 && sync_b) begin
        // rising edge passes unfiltered
        filt_out <= 1'b1;
        cnt <= {`SWF_DGL_CNT_W{1'b0}};
      end else if (cnt >= DGL_CYC - 1'b1) begin
        filt_out <= sync_b;
        cnt <= {`SWF_DGL_CNT_W{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule // swf_deglitch

`default_nettype wire

// >>> logic/swf_frame_check.v
`timescale 1ns/1ps
`default_nettype none
`include "swf_defines.vh"

module swf_frame_check (
  // clock and control
  input wire sys_clk,
  input wire srst,
  input wire clk_en,
  // serial pins
  input wire serial_frame_select_n,
  input wire serial_clock_pin,
  input wire serial_data_in,
  // frame results
  output reg frame_done,
  output reg frame_len_err,
  output reg [`SWF_FRAME_W-1:0] frame_word
);

  reg [2:0] sel_s;
  reg [2:0] sck_s;
  reg [1:0] sdi_s;
  reg [`SWF_EDGE_CNT_W-1:0] edge_cnt;
  reg any_edge;
  wire sel_end = sel_s[1] & ~sel_s[2];
  wire sel_start = ~sel_s[1] & sel_s[2];
  wire sck_rise = sck_s[1] & ~sck_s[2];

  // ****************************************
  // edge count per select period
  // ****************************************
  always @(posedge sys_clk) begin
    if (srst) begin
      sel_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 2'h0;
      edge_cnt <= {`SWF_EDGE_CNT_W{1'b0}};
      any_edge <= 1'b0;
      frame_done <= 1'b0;
      frame_len_err <= 1'b0;
      frame_word <= {`SWF_FRAME_W{1'b0}};
    end else if (clk_en) begin
      sel_s <= {sel_s[1:0], serial_frame_select_n};
      sck_s <= {sck_s[1:0], serial_clock_pin};
      sdi_s <= {sdi_s[0], serial_data_in};
      frame_done <= sel_end;
      if (sel_start) begin
        edge_cnt <= {`SWF_EDGE_CNT_W{1'b0}};
        any_edge <= 1'b0;
      end else if (!sel_s[1] && sck_rise) begin
        edge_cnt <= edge_cnt + 1'b1;
        any_edge <= 1'b1;
        frame_word <= {frame_word[`SWF_FRAME_W-2:0], sdi_s[1]};
      end
      // high bits wrap harmlessly, so only the low bits are checked
      if (sel_end) begin
        frame_len_err <= ~any_edge | (|edge_cnt[`SWF_FRAME_MOD_MSB:0]); // [RQ4]
      end
    end
  end

endmodule // swf_frame_check

`default_nettype wire

// >>> logic/swf_supervisor.v
// Notes on behaviour
// RQ1 - any serial link fault forces the device out of normal into fail mode
// RQ2 - host inverts the toggle bit every frame; unchanged bit is a link fault
// RQ3 - no valid frame within 32 ms or 128 ms, by select bit, is a fault
// RQ4 - clock edges per select period not a multiple of 16 is a fault
// RQ5 - stuck data or dead supply only show up as toggle mismatch
// RQ6 - a link fault sets the fault flag, returned in the next transfer
// RQ7 - fault flag stays set for the whole time in fail mode
// RQ8 - fault flag clears on the step from fail back to normal mode
// RQ9 - fail input and four direct inputs filtered on both edges, 200 us
// RQ10 - fail input high past the filter time raises fail request, enters fail
// RQ11 - direct input high past the filter time drives its output filtered
// RQ12 - reset pin filtered 10 us on falling edge only, rising passes at once
// RQ13 - external clock filtered 2.0 us both edges; too fast counts as failure
// RQ14 - clock monitoring starts right at the rising edge of the reset pin
// RQ15 - clock below 100 Hz: outputs follow channel on bits, not duty cycle
// RQ16 - clock back in limits: outputs return to programmed duty cycle
// RQ17 - clock failure flag clears only once gone and status 1 is read; here a low filtered reset pin also clears it
// RQ18 - external switch control driven in normal mode from channel 6 setting
// RQ19 - external switch control held off in sleep and fail modes
// RQ20 - in fail mode each output follows its filtered direct input
// RQ21 - present fail input level reported as its own status bit
// RQ22 - toggle compared against previous valid frame; timeout restarts each frame; here a frame with a length error does not restart it
`timescale 1ns/1ps
`default_nettype none
`include "swf_defines.vh"

module swf_supervisor #(
  parameter [`SWF_DGL_CNT_W-1:0] IN_DGL_CYC = `SWF_IN_DGL_CYC,
  parameter [`SWF_LONG_CNT_W-1:0] WD_SHORT_CYC = `SWF_WD_SHORT_CYC,
  parameter [`SWF_LONG_CNT_W-1:0] WD_LONG_CYC = `SWF_WD_LONG_CYC,
  parameter [`SWF_LONG_CNT_W-1:0] CLK_LOW_CYC = `SWF_CLK_LOW_CYC
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire srst,
  input wire clk_en,
  // direct pins
  input wire active_low_reset_pin,
  input wire fail_mode_pin,
  input wire [`SWF_NUM_CH-1:0] direct_channel_inputs,
  input wire ext_pwm_clock_pin,
  // serial link pins
  input wire serial_frame_select_n,
  input wire serial_clock_pin,
  input wire serial_data_in,
  // control bits from the register logic
  input wire watchdog_period_select,
  input wire [`SWF_NUM_CH-1:0] channel_on_control_bit,
  input wire [`SWF_NUM_CH-1:0] pwm_channel_drive,
  input wire channel6_setting,
  input wire quick_status1_read,
  // outputs
  output reg [`SWF_NUM_CH-1:0] power_out,
  output reg external_switch_control_out,
  // status
  output reg serial_link_fault_flag,
  output reg fail_input_level,
  output reg clock_fail_flag,
  output reg fail_mode,
  output reg sleep_mode
);

  // ****************************************
  // state encodings and filter lengths
  // ****************************************
  localparam [1:0] ST_SLEEP = `SWF_ST_SLEEP;
  localparam [1:0] ST_NORMAL = `SWF_ST_NORMAL;
  localparam [1:0] ST_FAIL = `SWF_ST_FAIL;
  localparam [`SWF_DGL_CNT_W-1:0] RST_DGL_CYC = `SWF_RST_DGL_CYC;
  localparam [`SWF_DGL_CNT_W-1:0] CLK_DGL_CYC = `SWF_CLK_DGL_CYC;

  // ****************************************
  // declarations
  // ****************************************
  wire reset_pin_filt;
  wire filtered_fail_request;
  wire [`SWF_NUM_CH-1:0] filtered_direct_input;
  wire ext_clk_filt;
  wire frame_done;
  wire frame_len_err;
  wire [`SWF_FRAME_W-1:0] frame_word;

  reg [1:0] mode_state;
  reg [1:0] next_mode_state;
  reg prev_toggle;
  reg have_prev;
  reg [`SWF_LONG_CNT_W-1:0] wd_cnt;
  reg ext_clk_d;
  reg [`SWF_LONG_CNT_W-1:0] clk_gap_cnt;
  reg clk_fail_cond;

  wire toggle_bit;
  wire frame_valid;
  wire toggle_err;
  wire wd_timeout;
  wire link_fault;
  wire frame_good;
  wire [`SWF_LONG_CNT_W-1:0] wd_limit;
  wire ext_clk_rise;

  // saturating up-count shared by both long timers
  function [`SWF_LONG_CNT_W-1:0] sat_inc;
    input [`SWF_LONG_CNT_W-1:0] val;
    input [`SWF_LONG_CNT_W-1:0] lim;
    begin
      if (val >= lim) begin
        sat_inc = lim;
      end else begin
        sat_inc = val + 1'b1;
      end
    end
  endfunction

  // ****************************************
  // input filters
  // ****************************************
  swf_deglitch #(
    .DGL_CYC(RST_DGL_CYC),
    .FALL_ONLY(1)
  ) u_rst_dgl (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_in(active_low_reset_pin), // [RQ12]
    .filt_out(reset_pin_filt)
  );

  swf_deglitch #(
    .DGL_CYC(IN_DGL_CYC),
    .FALL_ONLY(0)
  ) u_fail_dgl (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_in(fail_mode_pin), // [RQ9]
    .filt_out(filtered_fail_request)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `SWF_NUM_CH; gi = gi + 1) begin : g_in_dgl
      swf_deglitch #(
        .DGL_CYC(IN_DGL_CYC),
        .FALL_ONLY(0)
      ) u_in_dgl (
        .sys_clk(sys_clk),
        .srst(srst),
        .clk_en(clk_en),
        .pin_in(direct_channel_inputs[gi]), // [RQ9]
        .filt_out(filtered_direct_input[gi])
      );
    end
  endgenerate

  // a clock faster than the filter never gets through, so it reads as stopped
  swf_deglitch #(
    .DGL_CYC(CLK_DGL_CYC),
    .FALL_ONLY(0)
  ) u_clk_dgl (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_in(ext_pwm_clock_pin), // [RQ13]
    .filt_out(ext_clk_filt)
  );

  // ****************************************
  // serial frame length check
  // ****************************************
  swf_frame_check u_frame (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .serial_frame_select_n(serial_frame_select_n),
    .serial_clock_pin(serial_clock_pin),
    .serial_data_in(serial_data_in),
    .frame_done(frame_done),
    .frame_len_err(frame_len_err),
    .frame_word(frame_word)
  );

  // ****************************************
  // watchdog checks
  // ****************************************
  assign toggle_bit = frame_word[`SWF_WD_BIT_POS];
  assign frame_valid = frame_done & ~frame_len_err;
  // stuck data or dead supply has no detector of its own
  assign toggle_err = frame_valid & have_prev & (toggle_bit == prev_toggle); // [RQ2] [RQ5]
  assign wd_limit = watchdog_period_select ? WD_LONG_CYC : WD_SHORT_CYC;
  assign wd_timeout = (mode_state != ST_SLEEP) && (wd_cnt >= wd_limit - 1'b1); // [RQ3]
  assign link_fault = (frame_done & frame_len_err) | toggle_err | wd_timeout; // [RQ4]
  assign frame_good = frame_valid & ~toggle_err;

  always @(posedge sys_clk) begin
    if (srst) begin
      prev_toggle <= 1'b0;
      have_prev <= 1'b0;
      wd_cnt <= {`SWF_LONG_CNT_W{1'b0}};
    end else if (clk_en) begin
      if (mode_state == ST_SLEEP) begin
        have_prev <= 1'b0;
        wd_cnt <= {`SWF_LONG_CNT_W{1'b0}};
      end else if (frame_valid) begin
        prev_toggle <= toggle_bit; // [RQ22]
        have_prev <= 1'b1;
        wd_cnt <= {`SWF_LONG_CNT_W{1'b0}}; // [RQ22]
      end else if (wd_timeout) begin
        wd_cnt <= {`SWF_LONG_CNT_W{1'b0}};
      end else begin
        wd_cnt <= sat_inc(wd_cnt, wd_limit);
      end
    end
  end

  // ****************************************
  // mode sequencing
  // ****************************************
  always @* begin
    next_mode_state = mode_state;
    case (mode_state)
      ST_SLEEP: begin
        if (reset_pin_filt) begin
          // a bad frame caught on the wake-up cycle must not be lost
          if (filtered_fail_request || link_fault) begin
            next_mode_state = ST_FAIL; // [RQ1]
          end else begin
            next_mode_state = ST_NORMAL;
          end
        end
      end
      ST_NORMAL: begin
        if (link_fault || filtered_fail_request) begin
          next_mode_state = ST_FAIL; // [RQ1] [RQ10]
        end
      end
      ST_FAIL: begin
        // leaving needs a clean frame and no fail request
        if (frame_good && !filtered_fail_request && !link_fault) begin
          next_mode_state = ST_NORMAL;
        end
      end
      default: begin
        next_mode_state = ST_SLEEP;
      end
    endcase
    if (!reset_pin_filt) begin
      next_mode_state = ST_SLEEP;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      mode_state <= ST_SLEEP;
      serial_link_fault_flag <= 1'b0;
    end else if (clk_en) begin
      mode_state <= next_mode_state;
      if (next_mode_state == ST_SLEEP) begin
        serial_link_fault_flag <= 1'b0;
      end else if (link_fault) begin
        serial_link_fault_flag <= 1'b1; // [RQ6] [RQ7]
      end else if (mode_state == ST_FAIL && next_mode_state == ST_NORMAL) begin
        serial_link_fault_flag <= 1'b0; // [RQ8]
      end
    end
  end

  // ****************************************
  // external clock monitor
  // ****************************************
  assign ext_clk_rise = ext_clk_filt & ~ext_clk_d;

  always @(posedge sys_clk) begin
    if (srst) begin
      ext_clk_d <= 1'b0;
      clk_gap_cnt <= {`SWF_LONG_CNT_W{1'b0}};
      clk_fail_cond <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else if (clk_en) begin
      ext_clk_d <= ext_clk_filt;
      if (!reset_pin_filt) begin
        // held at zero so counting starts on the reset release edge
        clk_gap_cnt <= {`SWF_LONG_CNT_W{1'b0}}; // [RQ14]
        clk_fail_cond <= 1'b0;
        clock_fail_flag <= 1'b0;
      end else begin
        if (ext_clk_rise) begin
          clk_gap_cnt <= {`SWF_LONG_CNT_W{1'b0}};
          clk_fail_cond <= 1'b0; // [RQ16]
        end else begin
          clk_gap_cnt <= sat_inc(clk_gap_cnt, CLK_LOW_CYC);
          if (clk_gap_cnt >= CLK_LOW_CYC - 1'b1) begin
            clk_fail_cond <= 1'b1; // [RQ15]
          end
        end
        if (clk_fail_cond) begin
          clock_fail_flag <= 1'b1;
        end else if (quick_status1_read) begin
          clock_fail_flag <= 1'b0; // [RQ17]
        end
      end
    end
  end

  // ****************************************
  // output steering
  // ****************************************
  always @(posedge sys_clk) begin
    if (srst) begin
      power_out <= {`SWF_NUM_CH{1'b0}};
      external_switch_control_out <= 1'b0;
      fail_input_level <= 1'b0;
      fail_mode <= 1'b0;
      sleep_mode <= 1'b1;
    end else if (clk_en) begin
      fail_input_level <= filtered_fail_request; // [RQ21]
      fail_mode <= (mode_state == ST_FAIL);
      sleep_mode <= (mode_state == ST_SLEEP);
      case (mode_state)
        ST_NORMAL: begin
          if (clk_fail_cond) begin
            power_out <= channel_on_control_bit; // [RQ15]
          end else begin
            power_out <= pwm_channel_drive; // [RQ16]
          end
          external_switch_control_out <= channel6_setting; // [RQ18]
        end
        ST_FAIL: begin
          power_out <= filtered_direct_input; // [RQ11] [RQ20]
          external_switch_control_out <= 1'b0; // [RQ19]
        end
        default: begin
          power_out <= {`SWF_NUM_CH{1'b0}};
          external_switch_control_out <= 1'b0; // [RQ19]
        end
      endcase
    end
  end

endmodule // swf_supervisor

`default_nettype wire

// >>> testbench/swf_supervisor_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "swf_defines.vh"
// ****
// mode and output relations
// ****
module swf_supervisor_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // inputs
  input wire logic active_low_reset_pin,
  input wire logic [`SWF_NUM_CH-1:0] pwm_channel_drive,
  input wire logic channel6_setting,
  input wire logic quick_status1_read,
  // outputs
  input wire logic [`SWF_NUM_CH-1:0] power_out,
  input wire logic external_switch_control_out,
  input wire logic serial_link_fault_flag,
  input wire logic clock_fail_flag,
  input wire logic fail_mode,
  input wire logic sleep_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || !clk_en);
  // two cycles so the registered outputs have caught up with the mode
  sequence s_normal;
    (!fail_mode && !sleep_mode) [*2];
  endsequence
  sequence s_exit;
    fail_mode ##1 !fail_mode;
  endsequence
  a_ext_off_fail: assert property (fail_mode [*2] |-> !external_switch_control_out)
    else $error("switch control on in fail mode");
  a_off_in_sleep: assert property (
    sleep_mode [*2] |-> !external_switch_control_out && power_out == 0)
    else $error("outputs on in sleep");
  a_ext_follows: assert property (
    s_normal |-> external_switch_control_out == $past(channel6_setting))
    else $error("switch control does not follow its setting");
  a_pwm_drive: assert property (
    s_normal ##0 !clock_fail_flag |-> power_out == $past(pwm_channel_drive))
    else $error("outputs do not follow pwm drive");
  a_flag_enters: assert property ($rose(serial_link_fault_flag) |=> fail_mode)
    else $error("link fault without fail mode");
  a_flag_only_fail: assert property (
    serial_link_fault_flag |-> fail_mode || $rose(serial_link_fault_flag))
    else $error("link fault flag outside fail mode");
  a_flag_clr_exit: assert property (
    $fell(serial_link_fault_flag) && active_low_reset_pin |-> s_exit)
    else $error("link fault flag cleared without leaving fail mode");
  a_clk_flag_read: assert property (
    $fell(clock_fail_flag) && active_low_reset_pin |-> $past(quick_status1_read))
    else $error("clock fail flag cleared without status read");
endmodule // swf_supervisor_checker
`default_nettype wire

// >>> testbench/swf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// host end of the serial link
// ****
module swf_host_model (
  // serial pins
  output logic serial_frame_select_n,
  output logic serial_clock_pin,
  output logic serial_data_in
);
  initial begin
    serial_frame_select_n = 1'b1;
    serial_clock_pin = 1'b0;
    serial_data_in = 1'b0;
  end
  // clock stands low outside frames; released data shows the inverse level
  task automatic send(input logic [31:0] w, input int n);
    serial_frame_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      #100 serial_clock_pin = 1'b1;
      #100 serial_clock_pin = 1'b0;
    end
    #100 serial_frame_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #200;
  endtask
endmodule // swf_host_model
`default_nettype wire

// >>> testbench/swf_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "swf_defines.vh"
// ****
// bench
// ****
module swf_supervisor_tb;
  localparam int WDS = 400;
  localparam int WDL = 1600;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic active_low_reset_pin = 1'b0;
  logic fail_mode_pin = 1'b0;
  logic [3:0] direct_channel_inputs = 4'h0;
  logic ext_pwm_clock_pin = 1'b0;
  logic ext_run = 1'b1;
  logic watchdog_period_select = 1'b0;
  logic [3:0] channel_on_control_bit = 4'h5;
  logic [3:0] pwm_channel_drive = 4'h9;
  logic channel6_setting = 1'b1;
  logic quick_status1_read = 1'b0;
  logic serial_frame_select_n, serial_clock_pin, serial_data_in;
  logic [3:0] power_out;
  logic external_switch_control_out, serial_link_fault_flag, fail_input_level;
  logic clock_fail_flag, fail_mode, sleep_mode;
  logic wd = 1'b0;
  int fails = 0;
  int check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  // half period of 200 cycles passes the 80 cycle clock filter
  always #5000 if (ext_run) ext_pwm_clock_pin = ~ext_pwm_clock_pin;
  swf_host_model host (.serial_frame_select_n(serial_frame_select_n),
    .serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in));
  swf_supervisor #(.IN_DGL_CYC(14'h0014), .WD_SHORT_CYC(23'h000190),
    .WD_LONG_CYC(23'h000640), .CLK_LOW_CYC(23'h0003e8)) dut (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .active_low_reset_pin(active_low_reset_pin), .fail_mode_pin(fail_mode_pin),
    .direct_channel_inputs(direct_channel_inputs), .ext_pwm_clock_pin(ext_pwm_clock_pin),
    .serial_frame_select_n(serial_frame_select_n), .serial_clock_pin(serial_clock_pin),
    .serial_data_in(serial_data_in), .watchdog_period_select(watchdog_period_select),
    .channel_on_control_bit(channel_on_control_bit), .pwm_channel_drive(pwm_channel_drive),
    .channel6_setting(channel6_setting), .quick_status1_read(quick_status1_read),
    .power_out(power_out), .external_switch_control_out(external_switch_control_out),
    .serial_link_fault_flag(serial_link_fault_flag), .fail_input_level(fail_input_level),
    .clock_fail_flag(clock_fail_flag), .fail_mode(fail_mode), .sleep_mode(sleep_mode));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = fail_mode;
      1: pick = sleep_mode;
      default: pick = clock_fail_flag;
    endcase
  endfunction
  task automatic wait_on(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("ERROR wait %0d expected %b seen %b", k, v, pick(k));
      give_verdict();
    end
  endtask
  task automatic frame_ok();
    wd = ~wd;
    host.send({16'h0, wd, 15'h1234}, 16);
  endtask
  task automatic t_startup();
    int n;
    check("ext sleep", external_switch_control_out, 1'b0);
    active_low_reset_pin = 1'b1;
    wait_on(1, 1'b0, 20, n);
    repeat (3) @(negedge sys_clk);
    check("fail", fail_mode, 1'b0);
    check("ext", external_switch_control_out, 1'b1);
    channel6_setting = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("ext off", external_switch_control_out, 1'b0);
    channel6_setting = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("pwm", power_out, 4'h9);
    frame_ok();
    $display("startup done");
  endtask
  task automatic t_toggle();
    int n;
    host.send({16'h0, {16{wd}}}, 16);
    wait_on(0, 1'b1, 20, n);
    check("flag", serial_link_fault_flag, 1'b1);
    direct_channel_inputs = 4'ha;
    repeat (30) @(negedge sys_clk);
    check("direct", power_out, 4'ha);
    check("ext fail", external_switch_control_out, 1'b0);
    direct_channel_inputs = 4'h5;
    repeat (10) @(negedge sys_clk);
    direct_channel_inputs = 4'ha;
    repeat (30) @(negedge sys_clk);
    check("glitch", power_out, 4'ha);
    host.send({16'h0, wd, 15'h0}, 16);
    check("flag held", serial_link_fault_flag, 1'b1);
    frame_ok();
    wait_on(0, 1'b0, 20, n);
    check("flag clear", serial_link_fault_flag, 1'b0);
    $display("toggle done");
  endtask
  task automatic t_length();
    int n;
    host.send({17'h0, ~wd, 14'h0}, 15);
    wait_on(0, 1'b1, 20, n);
    frame_ok();
    wait_on(0, 1'b0, 20, n);
    wd = ~wd;
    host.send({16'h0, wd, 15'h0}, 32);
    repeat (8) @(negedge sys_clk);
    check("long frame", fail_mode, 1'b0);
    $display("length done");
  endtask
  task automatic t_timeout();
    int n;
    int t;
    for (int s = 0; s < 2; s++) begin
      t = s ? WDL : WDS;
      watchdog_period_select = s[0];
      frame_ok();
      wait_on(0, 1'b1, t + 40, n);
      check("wd time", n >= t - 20, 1'b1);
      frame_ok();
      wait_on(0, 1'b0, 20, n);
    end
    $display("timeout done");
  endtask
  task automatic t_fail_pin();
    int n;
    fail_mode_pin = 1'b1;
    repeat (10) @(negedge sys_clk);
    fail_mode_pin = 1'b0;
    repeat (30) @(negedge sys_clk);
    check("short pin", fail_mode, 1'b0);
    fail_mode_pin = 1'b1;
    wait_on(0, 1'b1, 40, n);
    check("pin level", fail_input_level, 1'b1);
    check("no flag", serial_link_fault_flag, 1'b0);
    fail_mode_pin = 1'b0;
    repeat (30) @(negedge sys_clk);
    check("pin low", fail_input_level, 1'b0);
    frame_ok();
    wait_on(0, 1'b0, 20, n);
    $display("fail pin done");
  endtask
  task automatic t_clock();
    int n;
    frame_ok();
    ext_run = 1'b0;
    wait_on(2, 1'b1, 1300, n);
    repeat (2) @(negedge sys_clk);
    check("on bits", power_out, 4'h5);
    quick_status1_read = 1'b1;
    @(negedge sys_clk);
    quick_status1_read = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("read early", clock_fail_flag, 1'b1);
    frame_ok();
    ext_run = 1'b1;
    repeat (600) @(negedge sys_clk);
    check("pwm back", power_out, 4'h9);
    check("still latched", clock_fail_flag, 1'b1);
    quick_status1_read = 1'b1;
    @(negedge sys_clk);
    quick_status1_read = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("read clear", clock_fail_flag, 1'b0);
    frame_ok();
    $display("clock done");
  endtask
  task automatic t_reset_pin();
    int n;
    active_low_reset_pin = 1'b0;
    repeat (100) @(negedge sys_clk);
    active_low_reset_pin = 1'b1;
    repeat (10) @(negedge sys_clk);
    check("pin glitch", sleep_mode, 1'b0);
    frame_ok();
    active_low_reset_pin = 1'b0;
    wait_on(1, 1'b1, 450, n);
    check("pin filter", n >= 390, 1'b1);
    repeat (2) @(negedge sys_clk);
    check("sleep ext", external_switch_control_out, 1'b0);
    check("sleep out", power_out, 4'h0);
    $display("reset pin done");
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    t_startup();
    t_toggle();
    t_length();
    t_timeout();
    t_fail_pin();
    t_clock();
    t_reset_pin();
    give_verdict();
  end
endmodule // swf_supervisor_tb
bind swf_supervisor swf_supervisor_checker u_chk (.sys_clk(sys_clk), .srst(srst),
  .clk_en(clk_en), .active_low_reset_pin(active_low_reset_pin),
  .pwm_channel_drive(pwm_channel_drive), .channel6_setting(channel6_setting),
  .quick_status1_read(quick_status1_read), .power_out(power_out),
  .external_switch_control_out(external_switch_control_out),
  .serial_link_fault_flag(serial_link_fault_flag), .clock_fail_flag(clock_fail_flag),
  .fail_mode(fail_mode), .sleep_mode(sleep_mode));
`default_nettype wire
